// ==== design/ext_irq_decode.sv ====
// External interrupt pin decoder with boot chip select strap capture.
// Assumes pins are driven by outside sources and strap resistors, async
// to clk; the pin-function select bit comes from logic on clk.
`timescale 1ns/10ps

// Function
// - Select bit chooses encoded or dedicated pins
// - Dedicated function held through reset
// - Pins are active low inputs
// - Encoded level is inverse of pin value
// - Encoded 000 gives unmaskable level seven
// - Encoded 111 means no request
// - Dedicated pins raise levels seven, four, one
// - Pins sampled as boot straps at reset
// - Upper strap high: auto acknowledge, 15 waits
// - Lower straps pick 32, 8, 16 bit port
module ext_irq_decode
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Interrupt pins, active low
  input  wire ext_irq_pkg::level_t   encoded_level_pins_n,
  // Pin function: 1 encoded level, 0 dedicated requests
  input  wire logic                  pin_function_select_reg,
  // Decoded request
  output      ext_irq_pkg::level_t   irq_level,
  output      logic                  irq_nmi,
  output      logic                  irq_rise,
  output      logic                  encoded_mode,
  // Boot chip select configuration
  output      ext_irq_pkg::boot_cfg_s boot_cfg,
  output      logic                  strap_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic       encoded_mode;
    logic       strap_valid;
    logic [1:0] fill;
    level_t     irq_level;
    logic       irq_nmi;
    logic       irq_rise;
    boot_cfg_s  boot_cfg;
  } state_s;

  localparam state_s STATE_RESET = '{
    encoded_mode: MODE_RESET,
    strap_valid:  1'b0,
    fill:         2'h0,
    irq_level:    LEVEL_NONE,
    irq_nmi:      1'b0,
    irq_rise:     1'b0,
    boot_cfg:     BOOT_CFG_RESET
  };

  state_s st;
  state_s next_st;
  level_t pin_sync_n;

  pin_sync3 u_sync (
    .clk         (clk),
    .nrst        (nrst),
    .pins_n      (encoded_level_pins_n),
    .pins_sync_n (pin_sync_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st          = st;
    next_st.irq_rise = 1'b0;
    // Straps are taken once the synchroniser has refilled after release
    if (!st.strap_valid) begin
      if (st.fill == SYNC_FILL) begin
        next_st.strap_valid = 1'b1;
        if (pin_sync_n[PIN_UPPER]) begin
          next_st.boot_cfg.auto_acknowledge = 1'b1;
          next_st.boot_cfg.wait_states      = AA_WAITS;
        end else begin
          next_st.boot_cfg.auto_acknowledge = 1'b0;
          next_st.boot_cfg.wait_states      = NO_WAITS;
        end
        unique case (pin_sync_n[PIN_MIDDLE:PIN_LOWER])
          2'h0:    next_st.boot_cfg.port_size = PORT_32;
          2'h1:    next_st.boot_cfg.port_size = PORT_8;
          default: next_st.boot_cfg.port_size = PORT_16;
        endcase
      end else begin
        next_st.fill = st.fill + 2'h1;
      end
    end else begin
      next_st.encoded_mode = pin_function_select_reg;
    end
    // Requests are decoded only after the straps have been taken
    if (!st.strap_valid) begin
      next_st.irq_level = LEVEL_NONE;
    end else if (st.encoded_mode) begin
      next_st.irq_level = ~pin_sync_n;
    end else if (!pin_sync_n[PIN_UPPER]) begin
      next_st.irq_level = LEVEL_UPPER;
    end else if (!pin_sync_n[PIN_MIDDLE]) begin
      next_st.irq_level = LEVEL_MIDDLE;
    end else if (!pin_sync_n[PIN_LOWER]) begin
      next_st.irq_level = LEVEL_LOWER;
    end else begin
      next_st.irq_level = LEVEL_NONE;
    end
    next_st.irq_nmi  = (next_st.irq_level == LEVEL_NMI);
    next_st.irq_rise = (next_st.irq_level > st.irq_level);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign irq_level    = st.irq_level;
  assign irq_nmi      = st.irq_nmi;
  assign irq_rise     = st.irq_rise;
  assign encoded_mode = st.encoded_mode;
  assign boot_cfg     = st.boot_cfg;
  assign strap_valid  = st.strap_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  mode_dedicated_a: assert property (@(posedge clk) disable iff (!nrst)
    !st.strap_valid |-> !st.encoded_mode)
    else $error("pins left dedicated function before straps taken");

  mode_follow_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid |=> st.encoded_mode == $past(pin_function_select_reg))
    else $error("pin function does not follow select bit");

  encoded_level_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && st.encoded_mode |=> st.irq_level == ~$past(pin_sync_n))
    else $error("encoded level is not inverse of pins");

  nmi_level_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && st.encoded_mode && pin_sync_n == 3'h0
      |=> st.irq_nmi && st.irq_level == 3'h7)
    else $error("encoded 000 did not give level seven");

  no_request_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && st.encoded_mode && pin_sync_n == 3'h7
      |=> st.irq_level == 3'h0 && !st.irq_nmi)
    else $error("encoded 111 gave a request");

  dedicated_upper_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && !st.encoded_mode && !pin_sync_n[2]
      |=> st.irq_level == 3'h7)
    else $error("upper pin did not give level seven");

  dedicated_lower_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && !st.encoded_mode && pin_sync_n == 3'h6
      |=> st.irq_level == 3'h1)
    else $error("lower pin did not give level one");

  auto_ack_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.strap_valid) |-> st.boot_cfg.auto_acknowledge
      == $past(pin_sync_n[2]) && st.boot_cfg.wait_states
      == (st.boot_cfg.auto_acknowledge ? 4'hf : 4'h0))
    else $error("auto acknowledge strap mis-captured");

  port_size_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.strap_valid) |-> st.boot_cfg.port_size
      == ($past(pin_sync_n[1:0]) == 2'h0 ? 2'h0 :
          $past(pin_sync_n[1:0]) == 2'h1 ? 2'h1 : 2'h2))
    else $error("port size strap mis-captured");

  strap_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid |=> st.strap_valid && $stable(st.boot_cfg))
    else $error("boot straps changed after capture");

  strap_time_a: assert property (@(posedge clk) disable iff (!nrst)
    !st.strap_valid ##1 !st.strap_valid ##1 !st.strap_valid
      |=> st.strap_valid)
    else $error("straps not captured three edges after release");

  mid_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && !st.encoded_mode && pin_sync_n == 3'h5
      |=> st.irq_level == 3'h4)
    else $error("middle pin did not give level four");

  rise_event_a: assert property (@(posedge clk) disable iff (!nrst)
    st.irq_rise |-> st.irq_level > $past(st.irq_level))
    else $error("rise pulse without a higher level");

  rise_taken_a: assert property (@(posedge clk) disable iff (!nrst)
    st.irq_level > $past(st.irq_level) |-> st.irq_rise)
    else $error("higher level gave no rise pulse");

  nmi_match_a: assert property (@(posedge clk) disable iff (!nrst)
    st.irq_nmi == (st.irq_level == 3'h7))
    else $error("unmaskable flag does not match level seven");

  idle_pins_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid && pin_sync_n == 3'h7 |=> st.irq_level == 3'h0)
    else $error("idle high pins gave a request");

  no_decode_a: assert property (@(posedge clk) disable iff (!nrst)
    !st.strap_valid |-> st.irq_level == 3'h0 && !st.irq_rise)
    else $error("request decoded while straps pending");

  fill_done_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st.strap_valid) |-> $past(st.fill) == 2'h2)
    else $error("straps taken before synchroniser refilled");

  wait_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid |-> st.boot_cfg.wait_states
      == (st.boot_cfg.auto_acknowledge ? 4'hf : 4'h0))
    else $error("wait states do not match auto acknowledge");

  port_legal_a: assert property (@(posedge clk) disable iff (!nrst)
    st.strap_valid |-> st.boot_cfg.port_size != 2'h3)
    else $error("illegal boot port size");

endmodule : ext_irq_decode

// ==== design/ext_irq_pkg.sv ====
// Constants and carrier types for the external interrupt pin decoder.
// Assumes a single 250 MHz system clock and an active-low async reset.
package ext_irq_pkg;

  typedef logic [2:0] level_t;
  typedef logic [1:0] port_size_t;

  ////////////////////////////////////////////////////////////////////////////
  // Levels and pin values
  localparam level_t LEVEL_NONE    = 3'h0;
  localparam level_t LEVEL_UPPER   = 3'h7;
  localparam level_t LEVEL_MIDDLE  = 3'h4;
  localparam level_t LEVEL_LOWER   = 3'h1;
  localparam level_t LEVEL_NMI     = 3'h7;
  localparam level_t PINS_IDLE     = 3'h7;
  localparam int     PIN_UPPER     = 2;
  localparam int     PIN_MIDDLE    = 1;
  localparam int     PIN_LOWER     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Boot chip select strap decode
  localparam port_size_t PORT_32     = 2'h0;
  localparam port_size_t PORT_8      = 2'h1;
  localparam port_size_t PORT_16     = 2'h2;
  localparam logic [3:0] AA_WAITS    = 4'hf;
  localparam logic [3:0] NO_WAITS    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [1:0] SYNC_FILL   = 2'h2;
  localparam logic       MODE_RESET  = 1'b0;

  typedef struct packed {
    logic       auto_acknowledge;
    logic [3:0] wait_states;
    port_size_t port_size;
  } boot_cfg_s;

  localparam boot_cfg_s BOOT_CFG_RESET = '{
    auto_acknowledge: 1'b0,
    wait_states:      4'h0,
    port_size:        2'h0
  };

endpackage : ext_irq_pkg

// ==== design/pin_sync3.sv ====
// Two-flop synchroniser for the three interrupt pins.
// Assumes pins are asynchronous to clk; both stages reset to idle high.
`timescale 1ns/10ps

module pin_sync3
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Pins in, synchronised copy out
  input  wire ext_irq_pkg::level_t pins_n,
  output      ext_irq_pkg::level_t pins_sync_n
);

  level_t meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta        <= PINS_IDLE;
      pins_sync_n <= PINS_IDLE;
    end else begin
      meta        <= pins_n;
      pins_sync_n <= meta;
    end
  end

endmodule : pin_sync3

// ==== tb/irq_src_model.sv ====
// Outside interrupt sources and boot strap resistors on the three pins.
// Assumes the bench releases the straps once the decoder has taken them.
`timescale 1ns/10ps

module irq_src_model
  import ext_irq_pkg::*;
(
  // Strap window and strap values
  input  wire logic                strapping,
  input  wire ext_irq_pkg::level_t strap,
  // Requests, high means asserted
  input  wire ext_irq_pkg::level_t req,
  // Pins, active low
  output      ext_irq_pkg::level_t pins_n
);
  import ext_irq_pkg::*;

  // Straps own the pins until captured, then sources pull low to ask
  assign pins_n = strapping ? strap : ~req;
endmodule : irq_src_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the external interrupt pin decoder.
// Assumes irq_src_model drives the pins.
`timescale 1ns/10ps

module tb_top;
  import ext_irq_pkg::*;

  logic       clk;
  logic       nrst;
  logic       sel;
  level_t     strap;
  level_t     req;
  level_t     pins_n;
  level_t     irq_level;
  logic       irq_nmi;
  logic       irq_rise;
  logic       encoded_mode;
  boot_cfg_s  boot_cfg;
  logic       strap_valid;
  int         mismatches;
  int         n_checks;
  level_t     prev;
  logic       prev_sel;
  level_t     straps [4] = '{3'h0, 3'h2, 3'h7, 3'h4};
  // Rows: select, pin value, expected level
  logic [6:0] rows [16] = '{7'h38, 7'h31, 7'h2c, 7'h24, 7'h1f, 7'h38,
    7'h78, 7'h71, 7'h6a, 7'h63, 7'h5c, 7'h55, 7'h4e, 7'h47, 7'h78, 7'h4e};

  ext_irq_decode ext_irq_decode_i (.clk(clk), .nrst(nrst),
    .encoded_level_pins_n(pins_n), .pin_function_select_reg(sel),
    .irq_level(irq_level), .irq_nmi(irq_nmi), .irq_rise(irq_rise),
    .encoded_mode(encoded_mode), .boot_cfg(boot_cfg),
    .strap_valid(strap_valid));

  irq_src_model irq_src_model_i (.strapping(~strap_valid), .strap(strap),
    .req(req), .pins_n(pins_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic boot_cfg_s exp_cfg(input level_t s);
    exp_cfg.auto_acknowledge = s[2];
    exp_cfg.wait_states = s[2] ? AA_WAITS : NO_WAITS;
    exp_cfg.port_size = (s[1:0] == 2'h0) ? PORT_32 :
                        (s[1:0] == 2'h1) ? PORT_8 : PORT_16;
  endfunction : exp_cfg

  ////////////////////////////////////////////////////////////////////////////
  // Reset with straps fitted, then wait for capture
  task automatic do_reset(input level_t s);
    int n;
    @(negedge clk);
    nrst = 1'b0;
    strap = s;
    req = 3'h0;
    repeat (4) @(negedge clk);
    check(irq_level, LEVEL_NONE);
    check(encoded_mode, 1'b0);
    check(strap_valid, 1'b0);
    check(boot_cfg, BOOT_CFG_RESET);
    nrst = 1'b1;
    n = 0;
    while (strap_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check(8'(n), 8'h3);
    if (n == 8) test_done();
    check(boot_cfg, exp_cfg(s));
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    nrst = 1'b0;
    sel = 1'b0;
    strap = 3'h0;
    req = 3'h0;
    mismatches = 0;
    n_checks = 0;
    prev = 3'h0;
    prev_sel = 1'b0;
    do_reset(3'h5);
    foreach (rows[i]) begin
      sel = rows[i][6];
      req = ~rows[i][5:3];
      repeat (3) @(negedge clk);
      check(irq_level, rows[i][2:0]);
      check(irq_nmi, rows[i][2:0] == 3'h7);
      check(encoded_mode, sel);
      if (sel == prev_sel) check(irq_rise, rows[i][2:0] > prev);
      prev = rows[i][2:0];
      prev_sel = sel;
    end
    // Later pin activity must not disturb the captured straps
    check(boot_cfg, exp_cfg(3'h5));
    sel = 1'b1;
    foreach (straps[i]) do_reset(straps[i]);
    test_done();
  end
endmodule : tb_top
